// ===== oag_top.sv
// oag_top: effective address and immediate extension, one registered stage
// assumes register file reads are combinational and same-clock
`default_nettype none
module oag_top #(
  parameter int DATA_W = oag_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from decoder
  input wire oag_pkg::oag_req_t req_i,
  // register file values
  input wire logic [DATA_W-1:0] sel_reg_val_i,
  input wire logic [DATA_W-1:0] idx_reg_zero_i,
  input wire logic [DATA_W-1:0] global_base_register_i,
  // register file read select
  output logic [oag_pkg::REG_NUM_W-1:0] sel_reg_num_o,
  // result
  output oag_pkg::oag_resp_t resp_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] size_step(oag_pkg::oag_size_t s);
    case (s)
      oag_pkg::OAG_SZ_WORD: size_step = oag_pkg::STEP_WORD;
      oag_pkg::OAG_SZ_LONG: size_step = oag_pkg::STEP_LONG;
      default: size_step = oag_pkg::STEP_BYTE;
    endcase
  endfunction : size_step

  // scaled zero-extended offset, used for both 4- and 8-bit fields
  function automatic logic [DATA_W-1:0] scale_off(logic [7:0] f,
                                                  oag_pkg::oag_size_t s);
    logic [DATA_W-1:0] z;
    z = {{(DATA_W-8){1'b0}}, f};
    case (s)
      oag_pkg::OAG_SZ_WORD: scale_off = z << 1;
      oag_pkg::OAG_SZ_LONG: scale_off = z << 2;
      default: scale_off = z;
    endcase
  endfunction : scale_off

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  oag_pkg::oag_fields_t fields;
  oag_decode u_decode (
    .instr_i(req_i.instr),
    .fields_o(fields)
  );

  wire logic [7:0] imm8 = req_i.instr[oag_pkg::I8_HI:oag_pkg::I8_LO];
  wire logic [7:0] disp4_ext = {4'h0, fields.low_field};
  // source field selects register when the op names mmmm
  assign sel_reg_num_o = req_i.use_src ? fields.src_num : fields.dst_num;

  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  wire logic [DATA_W-1:0] step = size_step(req_i.size);
  wire logic [DATA_W-1:0] inc_val = sel_reg_val_i + step;
  wire logic [DATA_W-1:0] dec_val = sel_reg_val_i - step;
  wire logic [DATA_W-1:0] disp4_addr =
    sel_reg_val_i + scale_off(disp4_ext, req_i.size);
  wire logic [DATA_W-1:0] gbr_addr =
    global_base_register_i + scale_off(imm8, req_i.size);
  wire logic [DATA_W-1:0] gbr_idx_addr =
    global_base_register_i + idx_reg_zero_i;
  wire logic [DATA_W-1:0] reg_idx_addr =
    sel_reg_val_i + idx_reg_zero_i;
  wire logic [DATA_W-1:0] imm_zx = {{(DATA_W-8){1'b0}}, imm8};
  wire logic [DATA_W-1:0] imm_sx = {{(DATA_W-8){imm8[7]}}, imm8};
  wire logic [DATA_W-1:0] trap_off = imm_zx << oag_pkg::TRAP_SHIFT;

  logic [DATA_W-1:0] addr_sel;
  logic [DATA_W-1:0] oper_sel;
  logic mem_sel;
  logic wb_sel;
  logic [DATA_W-1:0] wb_val;

  always_comb begin
    addr_sel = '0;
    oper_sel = '0;
    mem_sel = 1'b1;
    wb_sel = 1'b0;
    wb_val = '0;
    case (req_i.mode)
      oag_pkg::OAG_AM_REG: begin
        oper_sel = sel_reg_val_i;
        mem_sel = 1'b0;
      end
      oag_pkg::OAG_AM_IND: addr_sel = sel_reg_val_i;
      oag_pkg::OAG_AM_POSTINC: begin
        addr_sel = sel_reg_val_i;
        wb_sel = 1'b1;
        wb_val = inc_val;
      end
      oag_pkg::OAG_AM_PREDEC: begin
        addr_sel = dec_val;
        wb_sel = 1'b1;
        wb_val = dec_val;
      end
      oag_pkg::OAG_AM_DISP4: addr_sel = disp4_addr;
      oag_pkg::OAG_AM_IDX_REG: addr_sel = reg_idx_addr;
      oag_pkg::OAG_AM_GBR_DISP: addr_sel = gbr_addr;
      oag_pkg::OAG_AM_GBR_IDX: addr_sel = gbr_idx_addr;
      oag_pkg::OAG_AM_IMM_ZX: begin
        oper_sel = imm_zx;
        mem_sel = 1'b0;
      end
      oag_pkg::OAG_AM_IMM_SX: begin
        oper_sel = imm_sx;
        mem_sel = 1'b0;
      end
      oag_pkg::OAG_AM_TRAP: begin
        oper_sel = trap_off;
        mem_sel = 1'b0;
      end
      default: mem_sel = 1'b0;
    endcase
  end

  // byte accesses never fault, only wider ones check low bits
  wire logic word_mis = (addr_sel[1:0] & oag_pkg::ALIGN_WORD_MASK) != 2'h0;
  wire logic long_mis = (addr_sel[1:0] & oag_pkg::ALIGN_LONG_MASK) != 2'h0;
  wire logic mis = mem_sel &&
    ((req_i.size == oag_pkg::OAG_SZ_WORD && word_mis) ||
     (req_i.size == oag_pkg::OAG_SZ_LONG && long_mis));
  // write-back still reported on fault; the core decides to squash it

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  oag_pkg::oag_resp_t resp_d;
  oag_pkg::oag_resp_t resp_q;

  always_comb begin
    resp_d.valid = req_i.valid;
    resp_d.mem_access = req_i.valid && mem_sel;
    resp_d.addr = addr_sel;
    resp_d.operand = oper_sel;
    resp_d.wb_en = req_i.valid && wb_sel;
    resp_d.wb_num = sel_reg_num_o;
    resp_d.wb_data = wb_val;
    resp_d.addr_err = req_i.valid && mis;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

  assign resp_o = resp_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_direct_no_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_REG) |=>
    (!resp_o.mem_access && resp_o.operand == $past(sel_reg_val_i)))
    else $error("direct mode operand wrong");
  chk_ind_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_IND) |=>
    (resp_o.addr == $past(sel_reg_val_i) && !resp_o.wb_en))
    else $error("indirect address wrong");
  chk_postinc_wb: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_POSTINC &&
     req_i.size == oag_pkg::OAG_SZ_LONG) |=>
    (resp_o.wb_en && resp_o.addr == $past(sel_reg_val_i) &&
     resp_o.wb_data == resp_o.addr + 32'h0000_0004))
    else $error("post-increment wrong");
  chk_predec_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_PREDEC &&
     req_i.size == oag_pkg::OAG_SZ_WORD) |=>
    (resp_o.wb_en && resp_o.addr == resp_o.wb_data &&
     resp_o.addr == $past(sel_reg_val_i) - 32'h0000_0002))
    else $error("pre-decrement wrong");
  chk_disp4_scale: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_DISP4 &&
     req_i.size == oag_pkg::OAG_SZ_LONG) |=>
    (resp_o.addr == $past(sel_reg_val_i) +
     {26'h0, $past(req_i.instr[3:0]), 2'h0}))
    else $error("disp4 scaling wrong");
  chk_gbr_disp: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_GBR_DISP &&
     req_i.size == oag_pkg::OAG_SZ_WORD) |=>
    (resp_o.addr == $past(global_base_register_i) +
     {23'h0, $past(req_i.instr[7:0]), 1'b0}))
    else $error("gbr disp wrong");
  chk_gbr_index: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_GBR_IDX) |=>
    (resp_o.addr == $past(global_base_register_i) + $past(idx_reg_zero_i)))
    else $error("gbr index wrong");
  chk_reg_index: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_IDX_REG) |=>
    (resp_o.addr == $past(sel_reg_val_i) + $past(idx_reg_zero_i)))
    else $error("register index wrong");
  chk_imm_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_IMM_ZX) |=>
    (resp_o.operand[31:8] == 24'h0 &&
     resp_o.operand[7:0] == $past(req_i.instr[7:0])))
    else $error("zero extension wrong");
  chk_imm_sign: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_IMM_SX) |=>
    (resp_o.operand[31:8] == {24{$past(req_i.instr[7])}}))
    else $error("sign extension wrong");
  chk_trap_vec: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i.valid && req_i.mode == oag_pkg::OAG_AM_TRAP) |=>
    (resp_o.operand == {22'h0, $past(req_i.instr[7:0]), 2'h0}))
    else $error("trap offset wrong");
  chk_field_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.use_src |-> sel_reg_num_o == req_i.instr[7:4])
    else $error("source field select wrong");
  chk_align_err: assert property (@(posedge clk_i) disable iff (rst_i)
    (resp_o.mem_access && resp_o.addr[1:0] != 2'h0 &&
     $past(req_i.size) == oag_pkg::OAG_SZ_LONG) |-> resp_o.addr_err)
    else $error("misaligned long not flagged");
endmodule : oag_top
`default_nettype wire

// ===== oag_pkg.sv
// oag_pkg: constants, types and rule summary for the operand address unit
// assumes a single cpu clock and a decoder that supplies instruction words
// Operation
// - register-direct mode passes the selected register value as operand, no address.
// - register-indirect mode uses the selected register value as the address.
// - post-increment uses the register as address then adds 1, 2 or 4 by size.
// - pre-decrement subtracts 1, 2 or 4 by size, writes back and uses that address.
// - register-plus-displacement adds a zero-extended 4-bit field to the register.
// - the 4-bit displacement is scaled by 1, 2 or 4 for byte, word, longword.
// - global-base displacement adds a zero-extended 8-bit field to the base register.
// - the 8-bit global-base offset is scaled by 1, 2 or 4 by size.
// - indexed global-base mode adds register zero to the base register.
// - the 8-bit immediate of bit-test and logic ops is zero-extended to 32 bits.
// - the 8-bit immediate of transfer, add and compare-equal is sign-extended.
// - the software-trap immediate is zero-extended and multiplied by four.
// - 4-bit instruction fields give opcode, source, destination, immediate or displacement.
// - a misaligned word or longword address raises an address error.
`default_nettype none
package oag_pkg;
  localparam int DATA_W = 32;
  localparam int REG_NUM_W = 4;
  localparam int NUM_REGS = 16;
  // instruction field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int DST_HI = 11;
  localparam int DST_LO = 8;
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 4;
  localparam int D4_HI = 3;
  localparam int D4_LO = 0;
  localparam int I8_HI = 7;
  localparam int I8_LO = 0;
  localparam int I8_W = 8;
  localparam int D4_W = 4;
  localparam logic [DATA_W-1:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [DATA_W-1:0] STEP_WORD = 32'h0000_0002;
  localparam logic [DATA_W-1:0] STEP_LONG = 32'h0000_0004;
  localparam logic [1:0] ALIGN_WORD_MASK = 2'h1;
  localparam logic [1:0] ALIGN_LONG_MASK = 2'h3;
  localparam int TRAP_SHIFT = 2;

  typedef enum logic [1:0] {
    OAG_SZ_BYTE,
    OAG_SZ_WORD,
    OAG_SZ_LONG
  } oag_size_t;

  typedef enum logic [3:0] {
    OAG_AM_REG,
    OAG_AM_IND,
    OAG_AM_POSTINC,
    OAG_AM_PREDEC,
    OAG_AM_DISP4,
    OAG_AM_IDX_REG,
    OAG_AM_GBR_DISP,
    OAG_AM_GBR_IDX,
    OAG_AM_IMM_ZX,
    OAG_AM_IMM_SX,
    OAG_AM_TRAP
  } oag_mode_t;

  typedef struct packed {
    logic [REG_NUM_W-1:0] opcode;
    logic [REG_NUM_W-1:0] dst_num;
    logic [REG_NUM_W-1:0] src_num;
    logic [REG_NUM_W-1:0] low_field;
  } oag_fields_t;

  typedef struct packed {
    logic valid;
    oag_mode_t mode;
    oag_size_t size;
    logic use_src;
    logic [15:0] instr;
  } oag_req_t;

  typedef struct packed {
    logic valid;
    logic mem_access;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] operand;
    logic wb_en;
    logic [REG_NUM_W-1:0] wb_num;
    logic [DATA_W-1:0] wb_data;
    logic addr_err;
  } oag_resp_t;
endpackage : oag_pkg
`default_nettype wire

// ===== oag_decode.sv
// oag_decode: splits a 16-bit instruction into its 4-bit fields
// assumes the instruction word is stable in the cycle it is used
`default_nettype none
module oag_decode (
  // instruction in
  input wire logic [15:0] instr_i,
  // fields out
  output oag_pkg::oag_fields_t fields_o
);
  // field meaning depends on opcode; this stage only slices
  assign fields_o.opcode = instr_i[oag_pkg::OPC_HI:oag_pkg::OPC_LO];
  assign fields_o.dst_num = instr_i[oag_pkg::DST_HI:oag_pkg::DST_LO];
  assign fields_o.src_num = instr_i[oag_pkg::SRC_HI:oag_pkg::SRC_LO];
  assign fields_o.low_field = instr_i[oag_pkg::D4_HI:oag_pkg::D4_LO];
endmodule : oag_decode
`default_nettype wire

// ===== oag_regfile_model.sv
// oag_regfile_model: register file and base register facing the unit
// assumes the bench loads every entry before it is read
`default_nettype none
module oag_regfile_model (
  // clock
  input wire logic clk_i,
  // read side
  input wire logic [3:0] rd_num_i,
  output logic [31:0] rd_val_o,
  output logic [31:0] r0_val_o,
  output logic [31:0] base_val_o,
  // load side, entry 16 is the base register
  input wire logic ld_en_i,
  input wire logic [4:0] ld_num_i,
  input wire logic [31:0] ld_val_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  // no reset: a real file powers up unknown
  logic [31:0] regs_q [0:16];
  always_ff @(posedge clk_i) begin
    if (ld_en_i) begin
      regs_q[ld_num_i] <= ld_val_i;
    end
  end
  // reads are combinational, same cycle as the select
  assign rd_val_o = regs_q[rd_num_i];
  assign r0_val_o = regs_q[0];
  assign base_val_o = regs_q[16];
endmodule : oag_regfile_model
`default_nettype wire

// ===== oag_top_tb.sv
// oag_top_tb: random and corner requests, checked one cycle later
// assumes the registered response stands for one cycle after each edge
`default_nettype none
module oag_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  oag_pkg::oag_req_t req_i = '0;
  oag_pkg::oag_resp_t resp_o, exp_q;
  logic [31:0] rd_val, r0_val, base_val, ld_val = 32'h0;
  logic [3:0] sel_num;
  logic ld_en = 1'b0;
  logic [4:0] ld_num = 5'h0;
  logic [31:0] mir [0:16];
  logic pend = 1'b0;
  int seed = 32'hc795;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clk_i = ~clk_i;
  oag_top #(.DATA_W(32)) DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .sel_reg_val_i(rd_val), .idx_reg_zero_i(r0_val),
    .global_base_register_i(base_val), .sel_reg_num_o(sel_num),
    .resp_o(resp_o));
  oag_regfile_model rf (.clk_i(clk_i), .rd_num_i(sel_num),
    .rd_val_o(rd_val), .r0_val_o(r0_val), .base_val_o(base_val),
    .ld_en_i(ld_en), .ld_num_i(ld_num), .ld_val_i(ld_val));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  function automatic oag_pkg::oag_resp_t expect_of(oag_pkg::oag_req_t r,
      logic [31:0] rv, logic [31:0] r0, logic [31:0] gb);
    oag_pkg::oag_resp_t e;
    logic [31:0] st;
    e = '0;
    st = 32'h1 << r.size;
    e.valid = r.valid;
    e.wb_num = r.use_src ? r.instr[7:4] : r.instr[11:8];
    e.mem_access = r.mode inside {[oag_pkg::OAG_AM_IND:oag_pkg::OAG_AM_GBR_IDX]};
    e.wb_en = r.mode inside {oag_pkg::OAG_AM_POSTINC, oag_pkg::OAG_AM_PREDEC};
    e.wb_data = (r.mode == oag_pkg::OAG_AM_POSTINC) ? rv + st : rv - st;
    case (r.mode)
      oag_pkg::OAG_AM_IND, oag_pkg::OAG_AM_POSTINC: e.addr = rv;
      oag_pkg::OAG_AM_PREDEC: e.addr = rv - st;
      oag_pkg::OAG_AM_DISP4: e.addr = rv + ({28'h0, r.instr[3:0]} << r.size);
      oag_pkg::OAG_AM_IDX_REG: e.addr = rv + r0;
      oag_pkg::OAG_AM_GBR_DISP: e.addr = gb + ({24'h0, r.instr[7:0]} << r.size);
      oag_pkg::OAG_AM_GBR_IDX: e.addr = gb + r0;
      default: e.addr = 32'h0;
    endcase
    case (r.mode)
      oag_pkg::OAG_AM_REG: e.operand = rv;
      oag_pkg::OAG_AM_IMM_ZX: e.operand = {24'h0, r.instr[7:0]};
      oag_pkg::OAG_AM_IMM_SX: e.operand = {{24{r.instr[7]}}, r.instr[7:0]};
      oag_pkg::OAG_AM_TRAP: e.operand = {22'h0, r.instr[7:0], 2'h0};
      default: e.operand = 32'h0;
    endcase
    e.addr_err = e.mem_access && ((r.size == oag_pkg::OAG_SZ_WORD && e.addr[0])
      || (r.size == oag_pkg::OAG_SZ_LONG && e.addr[1:0] != 2'h0));
    return e;
  endfunction : expect_of
  task automatic compare();
    check(32'(resp_o.valid), 32'(exp_q.valid));
    if (exp_q.valid === 1'b1) begin
      check(32'(resp_o.mem_access), 32'(exp_q.mem_access));
      check(32'(resp_o.wb_en), 32'(exp_q.wb_en));
      check(32'(resp_o.addr_err), 32'(exp_q.addr_err));
      if (exp_q.mem_access) check(resp_o.addr, exp_q.addr);
      else check(resp_o.operand, exp_q.operand);
      if (exp_q.wb_en) check(resp_o.wb_data, exp_q.wb_data);
      if (exp_q.wb_en) check(32'(resp_o.wb_num), 32'(exp_q.wb_num));
    end
  endtask : compare
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  // one request and one register load per cycle, back to back;
  // the load lands at the same edge, so the request sees the old value
  task automatic step();
    oag_pkg::oag_req_t r;
    logic [31:0] v;
    logic [4:0] ln;
    logic [3:0] num;
    @(negedge clk_i);
    if (pend) compare();
    v = $random(seed);
    r.valid = v[22:20] != 3'h0;
    r.mode = oag_pkg::oag_mode_t'(4'(($random(seed) & 15) % 12));
    r.size = oag_pkg::oag_size_t'(2'(($random(seed) & 3) % 3));
    r.use_src = v[16];
    r.instr = v[15:0];
    // sign boundary of the byte field and the largest nibble
    if (v[18:17] == 2'h0) r.instr[7:0] = {v[19], {7{~v[19]}}};
    num = r.use_src ? r.instr[7:4] : r.instr[11:8];
    req_i = r;
    exp_q = expect_of(r, mir[num], mir[0], mir[16]);
    pend = 1'b1;
    v = $random(seed);
    ln = 5'(($random(seed) & 31) % 17);
    ld_val = (v[2:0] == 3'h0) ? 32'hFFFF_FFFF : (v[2:0] == 3'h1) ? 32'h0 : v;
    ld_en = 1'b1;
    ld_num = ln;
    mir[ln] = ld_val;
    #1 check(32'(sel_num), 32'(num));
  endtask : step
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 17; i++) begin
      @(negedge clk_i);
      ld_en = 1'b1;
      ld_num = 5'(i);
      ld_val = $random(seed);
      mir[i] = ld_val;
    end
    repeat (1200) step();
    $display("test random stream done");
    @(negedge clk_i);
    compare();
    rst_i = 1'b1;
    req_i.valid = 1'b0;
    pend = 1'b0;
    #1 check(32'(resp_o.valid), 32'h0);
    check(resp_o.addr, 32'h0);
    @(negedge clk_i);
    rst_i = 1'b0;
    $display("test mid-run reset done");
    repeat (300) step();
    $display("test restart stream done");
    print_verdict();
  end
endmodule : oag_top_tb
`default_nettype wire
